// ===== power_mode_reset_ctrl.sv
// Purpose: Idle/stop power modes and reset sequencing with Avalon-MM registers
// Assumes: rst is the power-on event; all inputs synchronous to mclk
// Notes:   Data memory is never cleared here; only register state resets
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "pm_reset_consts.svh"

module power_mode_reset_ctrl
  import pm_reset_pkg::*;
#(
  parameter int unsigned POR_CYC = `POR_DELAY_CYC,
  parameter int unsigned MCD_CYC = `MCD_TIMEOUT_CYC
)(
  // Clock and power-on reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // CPU side
  input  wire logic        instr_retire,
  input  wire logic        irq_pending,
  output logic             cpu_wake,
  output logic             pc_clear,
  output logic      [15:0] boot_addr,
  // Analog and external reset sources
  input  wire logic        supply_above_thr,
  input  wire logic        ext_reset_n,
  input  wire logic        wdt_timeout,
  input  wire logic        osc_sample,
  // Reset and clock outputs
  output logic             sys_reset,
  output logic             rst_pin_out,
  output logic             rst_pin_oe,
  output logic             port_force_ones,
  output logic             weak_pullup_en,
  output clk_ctrl_s        clk_ctrl,
  output logic             wdt_enable,
  output logic             wdt_tick
);

  // ==========================================================
  // Declarations
  pm_state_e   state_reg;                 // Sequencer state
  logic [31:0] cnt_reg;                   // Delay and hold counter
  cause_s      cause_reg;                 // Last reset cause
  logic [5:0]  gp_flags_reg;              // Plain storage flags
  logic        idle_req_reg;              // Idle written, awaiting retire
  logic        stop_req_reg;              // Stop written, awaiting retire
  logic        mon_en_reg;                // Supply monitor enable
  logic        mon_src_reg;               // Monitor selected as source
  logic        mcd_en_reg;                // Missing-clock detector enable
  logic [31:0] mcd_cnt_reg;               // Cycles without clock activity
  logic        osc_prev_reg;              // Last sampled oscillator level
  logic [3:0]  wdt_div_reg;               // Divide-by-12 counter
  logic        ack_reg;                   // Bus answer cycle
  logic        mon_low;                   // Monitor reset condition
  logic        mcd_fire;                  // Detector timeout
  logic        reset_req;                 // Any reset request
  logic        wr_acc;                    // Write accepted this edge
  logic [7:0]  idx;                       // Register index
  logic        enter_mode;                // Idle or stop entered
  logic        leave_reset;               // Reset released at this edge

  // ==========================================================
  // Reset request combination
  assign mon_low   = mon_en_reg && mon_src_reg && !supply_above_thr;
  assign mcd_fire  = mcd_en_reg && (mcd_cnt_reg == MCD_CYC - 1);
  assign reset_req = mon_low || !ext_reset_n || wdt_timeout || mcd_fire;
  assign idx       = address[9:2];
  assign wr_acc    = write && ack_reg;
  assign enter_mode = instr_retire && (idle_req_reg || stop_req_reg)
                      && (state_reg == ST_RUN) && !reset_req;
  // Same terms as the sequencer exits, so exit strobes meet the falling reset
  assign leave_reset = (state_reg == ST_POR_DELAY && supply_above_thr
                        && cnt_reg == POR_CYC - 1)
                       || (state_reg == ST_RST_HOLD && !reset_req
                           && cnt_reg == `RST_HOLD_CYC - 1);

  // ==========================================================
  // Avalon handshake: one wait cycle, answer on the second
  always_ff @(posedge mclk)
  begin
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (read || write) && !ack_reg;
  end

  assign waitrequest = (read || write) && !ack_reg;

  // Read data loaded as the answer cycle begins
  always_ff @(posedge mclk)
  begin
    if (rst)
      readdata <= 32'h0000_0000;
    else if (read && !ack_reg)
    begin
      if (idx == `PMC_IDX)
        // Mode bits always read zero
        readdata <= {24'h00_0000, gp_flags_reg, 2'b00};
      else if (idx == `RCR_IDX)
        readdata <= {28'h000_0000, cause_reg};
      else if (idx == `SMC_IDX)
        readdata <= {24'h00_0000, mon_en_reg, supply_above_thr, 6'h00};
      else
        // Unmapped reads answer zero
        readdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Power control register and mode requests
  always_ff @(posedge mclk)
  begin
    if (rst || sys_reset)
    begin
      // Power control register and mode requests back to reset values
      gp_flags_reg <= 6'(`PMC_RESET >> 2);
      idle_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
    end
    else
    begin
      if (wr_acc && byteenable[0] && idx == `PMC_IDX)
        gp_flags_reg <= writedata[7:2];
      // A fresh write wins over the entry clear
      if (wr_acc && byteenable[0] && idx == `PMC_IDX && writedata[`PMC_IDLE_BIT])
        idle_req_reg <= 1'b1;
      else if (enter_mode)
        idle_req_reg <= 1'b0;
      if (wr_acc && byteenable[0] && idx == `PMC_IDX && writedata[`PMC_STOP_BIT])
        stop_req_reg <= 1'b1;
      else if (enter_mode)
        stop_req_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Supply monitor enable and source select
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      // Power-on alone turns the monitor off
      mon_en_reg  <= 1'b0;
      mon_src_reg <= 1'b0;
    end
    else if (wr_acc && byteenable[0])
    begin
      if (idx == `SMC_IDX)
        mon_en_reg <= writedata[`SMC_EN_BIT];
      else if (idx == `RCR_IDX && writedata[`RCR_POR_BIT])
        // Software must let the monitor settle first
        mon_src_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Missing-clock detector enable and one-shot
  always_ff @(posedge mclk)
  begin
    if (rst || sys_reset)
      mcd_en_reg <= 1'b0;
    else if (wr_acc && byteenable[0] && idx == `RCR_IDX)
      mcd_en_reg <= writedata[`RCR_MCD_BIT];
  end

  // Counts while the clock sample holds one level; active in stop
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      osc_prev_reg <= 1'b0;
      mcd_cnt_reg  <= 32'h0000_0000;
    end
    else
    begin
      osc_prev_reg <= osc_sample;
      if (!mcd_en_reg || osc_sample != osc_prev_reg || mcd_fire)
        mcd_cnt_reg <= 32'h0000_0000;
      else
        mcd_cnt_reg <= mcd_cnt_reg + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Watchdog clock at system clock over 12, stopped with peripherals
  always_ff @(posedge mclk)
  begin
    if (rst || sys_reset)
    begin
      wdt_div_reg <= 4'h0;
      wdt_tick    <= 1'b0;
    end
    else if (wdt_enable && clk_ctrl.periph_en)
    begin
      // Still ticking in idle so a hung sleep is caught
      wdt_tick    <= (wdt_div_reg == `WDT_DIV - 4'h1);
      wdt_div_reg <= (wdt_div_reg == `WDT_DIV - 4'h1) ? 4'h0 : wdt_div_reg + 4'h1;
    end
    else
      wdt_tick <= 1'b0;
  end

  // ==========================================================
  // Sequencer state, counter and reset cause
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= ST_POR_WAIT;
      cnt_reg   <= 32'h0000_0000;
      cause_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ST_POR_WAIT:
        begin
          cnt_reg <= 32'h0000_0000;
          if (supply_above_thr)
            state_reg <= ST_POR_DELAY;
        end
        ST_POR_DELAY:
        begin
          // Extra hold after the supply is good
          if (!supply_above_thr)
            state_reg <= ST_POR_WAIT;
          else if (cnt_reg == POR_CYC - 1)
          begin
            state_reg <= ST_RUN;
            cause_reg <= '{wdt: 1'b0, missing_clock_detector: 1'b0, por: 1'b1, pin: 1'b0};
          end
          else
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
        ST_RST_HOLD:
        begin
          // Held while any source stays active, then RST_HOLD_CYC more cycles
          if (reset_req)
            cnt_reg <= 32'h0000_0000;
          else if (cnt_reg == `RST_HOLD_CYC - 1)
            state_reg <= ST_RUN;
          else
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
        default:
        begin
          if (reset_req)
          begin
            // Ends run, idle and stop alike
            state_reg <= ST_RST_HOLD;
            cnt_reg   <= 32'h0000_0000;
            cause_reg <= '{wdt: wdt_timeout, missing_clock_detector: mcd_fire, por: 1'b0,
                           pin: !ext_reset_n};
          end
          else if (state_reg == ST_IDLE && irq_pending)
            state_reg <= ST_RUN;
          else if (enter_mode)
            // Stop wins when both bits are pending
            state_reg <= stop_req_reg ? ST_STOP : ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Reset outputs to core and pins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sys_reset       <= 1'b1;
      rst_pin_oe      <= 1'b1;
      port_force_ones <= 1'b1;
      weak_pullup_en  <= 1'b1;
    end
    else
    begin
      // Held through every reset state
      sys_reset       <= (state_reg == ST_POR_WAIT || state_reg == ST_POR_DELAY ||
                          state_reg == ST_RST_HOLD || reset_req) &&
                         !leave_reset;
      // Pin driven for power-on and monitor resets, until the hold ends
      rst_pin_oe      <= (state_reg == ST_POR_WAIT || state_reg == ST_POR_DELAY ||
                          mon_low || (rst_pin_oe && state_reg == ST_RST_HOLD)) &&
                         !leave_reset;
      port_force_ones <= sys_reset;
      weak_pullup_en  <= 1'b1;
    end
  end

  assign rst_pin_out = 1'b0;

  // ==========================================================
  // Clock enables, wake and reset-exit strobes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      clk_ctrl   <= '{cpu_en: 1'b0, periph_en: 1'b1, osc_run: 1'b1};
      cpu_wake   <= 1'b0;
      pc_clear   <= 1'b0;
      wdt_enable <= 1'b0;
      boot_addr  <= `BOOT_ADDR;
    end
    else
    begin
      cpu_wake <= 1'b0;
      pc_clear <= 1'b0;
      if (reset_req && state_reg >= ST_RUN)
        // Halt the CPU; oscillator back on for the reset
        clk_ctrl <= '{cpu_en: 1'b0, periph_en: 1'b1, osc_run: 1'b1};
      else if (leave_reset)
      begin
        // Leaving reset: PC cleared, watchdog running
        clk_ctrl   <= '{cpu_en: 1'b1, periph_en: 1'b1, osc_run: 1'b1};
        pc_clear   <= 1'b1;
        wdt_enable <= 1'b1;
        boot_addr  <= `BOOT_ADDR;
      end
      else if (enter_mode)
      begin
        // Switch only on retire so no runt pulse reaches the CPU
        if (stop_req_reg)
          clk_ctrl <= '{cpu_en: 1'b0, periph_en: 1'b0, osc_run: 1'b0};
        else
          clk_ctrl <= '{cpu_en: 1'b0, periph_en: 1'b1, osc_run: 1'b1};
      end
      else if (state_reg == ST_IDLE && irq_pending && !reset_req)
      begin
        // PC kept so service returns past the idle write
        clk_ctrl.cpu_en <= 1'b1;
        cpu_wake        <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Assertions
  idle_gate_a: assert property (@(posedge mclk) disable iff (rst)
    state_reg == ST_IDLE |-> !clk_ctrl.cpu_en && clk_ctrl.periph_en)
    else $error("CPU clock running in idle");
  idle_wake_a: assert property (@(posedge mclk) disable iff (rst)
    state_reg == ST_IDLE && irq_pending && !reset_req
    |=> state_reg == ST_RUN && cpu_wake && clk_ctrl.cpu_en && !pc_clear)
    else $error("Idle did not wake on interrupt");
  stop_hold_a: assert property (@(posedge mclk) disable iff (rst)
    state_reg == ST_STOP && !reset_req |=> state_reg == ST_STOP)
    else $error("Stop left without reset");
  stop_clk_a: assert property (@(posedge mclk) disable iff (rst)
    state_reg == ST_STOP |-> !clk_ctrl.osc_run && !clk_ctrl.periph_en)
    else $error("Clocks running in stop");
  mode_read_a: assert property (@(posedge mclk) disable iff (rst)
    read && !ack_reg && idx == `PMC_IDX |=> readdata[1:0] == 2'b00
    && readdata[7:2] == gp_flags_reg)
    else $error("Power control read wrong");
  mcd_reset_a: assert property (@(posedge mclk) disable iff (rst)
    mcd_fire && state_reg >= ST_RUN |=> state_reg == ST_RST_HOLD
    && cause_reg.missing_clock_detector && sys_reset)
    else $error("Missing clock did not reset");
  wdt_rate_a: assert property (@(posedge mclk) disable iff (rst)
    wdt_tick |=> !wdt_tick [*8])
    else $error("Watchdog tick too fast");
  pin_drive_a: assert property (@(posedge mclk) disable iff (rst)
    rst_pin_oe |-> sys_reset || $past(mon_low))
    else $error("Reset pin driven outside reset");
  por_flag_a: assert property (@(posedge mclk) disable iff (rst)
    state_reg == ST_RST_HOLD |-> !cause_reg.por)
    else $error("Power-on flag kept by other reset");
  reset_exit_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(sys_reset) |-> pc_clear && wdt_enable && clk_ctrl.cpu_en)
    else $error("Reset exit actions missing");
  gate_retire_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(clk_ctrl.cpu_en) |-> $past(instr_retire) || sys_reset
    || $past(reset_req))
    else $error("CPU clock cut mid-instruction");

  idle_wake_c: cover property (@(posedge mclk) disable iff (rst)
    state_reg == ST_IDLE ##1 cpu_wake);
  stop_exit_c: cover property (@(posedge mclk) disable iff (rst)
    state_reg == ST_STOP ##1 state_reg == ST_RST_HOLD);
  por_release_c: cover property (@(posedge mclk) disable iff (rst)
    state_reg == ST_POR_DELAY ##1 state_reg == ST_RUN);

endmodule
`default_nettype wire

// ===== pm_reset_consts.svh
// Purpose: Constants for the power-mode and reset sequencer
// Assumes: 100 MHz system clock, register index times four is the byte address
// Notes:   Definitions only; included by bare name
//
// Overview of operation
// - Idle bit gates CPU clock after instruction
// - Enabled interrupt or reset ends idle mode
// - Interrupt wake resumes without clearing program counter
// - Reset from idle restarts at address zero
// - Watchdog keeps counting in idle, resets
// - Stop bit halts oscillator, CPU, digital peripherals
// - Only resets end stop mode
// - Enabled missing-clock detector resets during stop
// - Stop and idle bits read zero
// - Upper six bits are plain flags
// - Reset halts CPU, resets registers, ports, interrupts
// - Reset keeps data memory, resets stack pointer
// - Port latches ones, pull-ups stay enabled
// - Reset pin driven low for power/monitor resets
// - Reset exit clears PC, starts watchdog div12
// - Power-up adds delay after supply good
// - Power-on sets flag; other resets clear it
// - Power-on disables monitor; others keep it
// - Monitor low holds reset until supply good
// - Missing-clock bit write enables or disables detector
`ifndef PM_RESET_CONSTS_SVH
`define PM_RESET_CONSTS_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS   10
`define POR_DELAY_NS    300000
`define POR_DELAY_CYC   ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MCD_TIMEOUT_NS  100000
`define MCD_TIMEOUT_CYC (`MCD_TIMEOUT_NS / `CLK_PERIOD_NS)
`define WDT_DIV         4'hC
`define RST_HOLD_CYC    4

// ==========================================================
// Register indexes (byte address is four times the index)
`define PMC_IDX 8'h87
`define RCR_IDX 8'hEF
`define SMC_IDX 8'hFF
`define PMC_RESET 8'h00

// ==========================================================
// Field positions
`define PMC_IDLE_BIT 0
`define PMC_STOP_BIT 1
`define RCR_PIN_BIT  0
`define RCR_POR_BIT  1
`define RCR_MCD_BIT  2
`define RCR_WDT_BIT  3
`define SMC_STAT_BIT 6
`define SMC_EN_BIT   7
`define BOOT_ADDR    16'h0000

`endif

// ===== pm_reset_pkg.sv
// Purpose: Types shared by the power-mode and reset sequencer
// Assumes: Nothing beyond the constants header
// Notes:   Types only
`default_nettype none
package pm_reset_pkg;
  // Operating state of the sequencer
  typedef enum logic [2:0] {
    ST_POR_WAIT,
    ST_POR_DELAY,
    ST_RST_HOLD,
    ST_RUN,
    ST_IDLE,
    ST_STOP
  } pm_state_e;

  // Cause of the last reset
  typedef struct packed {
    logic wdt;
    logic missing_clock_detector;
    logic por;
    logic pin;
  } cause_s;

  // Clock enables handed to the clock tree
  typedef struct packed {
    logic cpu_en;
    logic periph_en;
    logic osc_run;
  } clk_ctrl_s;
endpackage
`default_nettype wire

// ===== cpu_supply_model.sv
// Purpose: Stand-in for the CPU core, watchdog and clock activity sensor
// Assumes: Bench raises step, irq_req and wdt_req just after a clock edge
// Notes:   Clock activity freezes whenever the oscillator is stopped
`timescale 1ns/10ps
`default_nettype none
module cpu_supply_model
  import pm_reset_pkg::*;
(
  // Clock and bench controls
  input  wire logic       mclk,
  input  wire logic       step,
  input  wire logic       irq_req,
  input  wire logic       wdt_req,
  // Sequencer side
  input  wire clk_ctrl_s  clk_ctrl,
  output logic            instr_retire,
  output logic            irq_pending,
  output logic            wdt_timeout,
  output logic            osc_sample
);
  // ==========================================
  // Clock activity
  initial osc_sample = 1'b0;
  // Toggles only while the oscillator runs, so stop starves the detector
  always @(posedge mclk)
    if (clk_ctrl.osc_run)
      osc_sample <= ~osc_sample;

  // ==========================================
  // Core and watchdog
  // A gated CPU retires nothing; a multi-byte follow-up is retired on step
  always_ff @(posedge mclk)
    instr_retire <= step & clk_ctrl.cpu_en;
  // Enabled interrupt as a level, timeout as a pulse
  always_ff @(posedge mclk)
  begin
    irq_pending <= irq_req;
    wdt_timeout <= wdt_req;
  end
endmodule
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for the power-mode and reset sequencer
// Assumes: Shortened power-up and missing-clock counts via parameters
// Notes:   Expectations come from bench-side constants and a flag model
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pm_reset_pkg::*;
  // ==========================================
  // Shortened counts keep the run brief
  localparam int         POR_T = 20;
  localparam int         MCD_T = 30;
  localparam logic [9:0] PMC_A = 10'h21C;
  localparam logic [9:0] RCR_A = 10'h3BC;
  localparam logic [9:0] SMC_A = 10'h3FC;
  int          err_count = 0;
  int          compares = 0;
  int          pc_cnt = 0;     // Reset exits seen
  int          wake_cnt = 0;   // Interrupt wakes seen
  int          tick_gap = 0;   // Last watchdog tick spacing
  int          since_tick = 0;
  int          n;
  logic [7:0]  flags_m;        // Model of the flag bits
  logic [31:0] q;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  address = '0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = '0;
  logic [31:0] writedata = '0;
  logic        step = 1'b0;
  logic        irq_req = 1'b0;
  logic        wdt_req = 1'b0;
  logic        supply = 1'b1;  // Supply above threshold
  logic        pin_n = 1'b1;   // Reset pin level
  logic [31:0] readdata;
  logic        waitrequest, instr_retire, irq_pending, wdt_timeout, osc_sample;
  logic        cpu_wake, pc_clear, sys_reset, rst_pin_out, rst_pin_oe;
  logic        port_force_ones, weak_pullup_en, wdt_enable, wdt_tick;
  logic [15:0] boot_addr;
  clk_ctrl_s   clk_ctrl;

  // ==========================================
  // Clock and instances
  always #5 mclk = ~mclk;
  power_mode_reset_ctrl #(.POR_CYC(POR_T), .MCD_CYC(MCD_T)) dut (.mclk(mclk), .rst(rst),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .instr_retire(instr_retire), .irq_pending(irq_pending), .cpu_wake(cpu_wake),
    .pc_clear(pc_clear), .boot_addr(boot_addr), .supply_above_thr(supply),
    .ext_reset_n(pin_n), .wdt_timeout(wdt_timeout), .osc_sample(osc_sample),
    .sys_reset(sys_reset), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .port_force_ones(port_force_ones), .weak_pullup_en(weak_pullup_en),
    .clk_ctrl(clk_ctrl), .wdt_enable(wdt_enable), .wdt_tick(wdt_tick));
  cpu_supply_model partner (.mclk(mclk), .step(step), .irq_req(irq_req),
    .wdt_req(wdt_req), .clk_ctrl(clk_ctrl), .instr_retire(instr_retire),
    .irq_pending(irq_pending), .wdt_timeout(wdt_timeout), .osc_sample(osc_sample));

  // Pulse counters, so one-cycle pulses are never missed
  always @(posedge mclk)
  begin
    pc_cnt += (pc_clear === 1'b1);
    wake_cnt += (cpu_wake === 1'b1);
    since_tick++;
    if (wdt_tick === 1'b1)
    begin
      tick_gap = since_tick;
      since_tick = 0;
    end
  end

  // ==========================================
  // Tasks
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL at %0t: %s", $time, m);
    end
  endtask
  // One Avalon access; waits for waitrequest low, bounded
  task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d,
                     input logic be, output logic [31:0] r);
    int i;
    @(posedge mclk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= {24'h00_0000, d};
    byteenable <= {3'h0, be};
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (waitrequest === 1'b0)
        break;
    end
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 20)
    begin
      chk(1'h0, 1'h1, "bus access hung");
      give_verdict();
    end
  endtask
  // Counts edges until internal reset reaches lvl
  task automatic wait_rst(input logic lvl, input int lim, output int c);
    for (c = 0; c < lim && sys_reset !== lvl; c++)
      @(posedge mclk);
    if (sys_reset !== lvl)
    begin
      chk(1'h0, 1'h1, "reset wait ran out");
      give_verdict();
    end
  endtask
  // Write the mode register, then retire the following instruction
  task automatic enter(input logic [7:0] v);
    acc(1'b1, PMC_A, v, 1'b1, q);
    @(posedge mclk);
    step <= 1'b1;
    @(posedge mclk);
    step <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask
  task automatic reset_exit();
    wait_rst(1'b0, 60, n);
    repeat (3) @(posedge mclk);
  endtask

  // Hang guard
  initial
  begin
    repeat (90000) @(posedge mclk);
    chk(1'h0, 1'h1, "run hung");
    give_verdict();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    q = $urandom(32'he797);
    repeat (12) @(posedge mclk);
    chk({rst_pin_oe, rst_pin_out}, 2'h2, "pin not driven at power-on");
    chk({sys_reset, port_force_ones, weak_pullup_en}, 3'h7, "reset outputs");
    chk(clk_ctrl.cpu_en, 1'h0, "cpu clock on in reset");
    rst <= 1'b0;
    wait_rst(1'b0, 200, n);
    chk(n >= POR_T - 2, 1'h1, "power-up delay short");
    repeat (3) @(posedge mclk);
    chk(pc_cnt, 1, "pc clear pulse");
    chk({wdt_enable, clk_ctrl, boot_addr}, {4'hF, 16'h0000}, "exit state");
    chk({rst_pin_oe, weak_pullup_en, port_force_ones}, 3'h2, "pin and pull-ups");
    acc(1'b0, RCR_A, 8'h00, 1'b0, q);
    chk(q & 32'h0000_0002, 32'h0000_0002, "power-on flag");
    acc(1'b0, SMC_A, 8'h00, 1'b0, q);
    chk(q[7], 1'h0, "monitor enabled after power-on");
    $display("test power-up done");
    for (int k = 0; k < 4; k++)
    begin
      flags_m = 8'($urandom()) & 8'hFC;
      acc(1'b1, PMC_A, flags_m, 1'b1, q);
      acc(1'b1, PMC_A, ~flags_m, 1'b0, q); // Lane off: must be ignored
      acc(1'b0, PMC_A, 8'h00, 1'b0, q);
      chk(q, {24'h00_0000, flags_m}, "flag readback");
      acc(1'b0, 10'h100, 8'h00, 1'b0, q);
      chk(q, 32'h0000_0000, "unmapped read");
    end
    $display("test registers done");
    enter(flags_m | 8'h01);
    chk(clk_ctrl, 3'h3, "idle clocks");
    acc(1'b0, PMC_A, 8'h00, 1'b0, q);
    chk(q, {24'h00_0000, flags_m}, "flags in idle");
    n = wake_cnt;
    irq_req <= 1'b1;
    repeat (4) @(posedge mclk);
    irq_req <= 1'b0;
    chk(wake_cnt, n + 1, "wake pulse");
    chk({clk_ctrl, sys_reset}, 4'hE, "wake clocks");
    chk(pc_cnt, 1, "wake cleared pc");
    $display("test idle done");
    enter(8'hA5);
    wdt_req <= 1'b1;
    @(posedge mclk);
    wdt_req <= 1'b0;
    wait_rst(1'b1, 20, n);
    reset_exit();
    chk(pc_cnt, 2, "restart from idle");
    acc(1'b0, RCR_A, 8'h00, 1'b0, q);
    chk(q & 32'h0000_000A, 32'h0000_0008, "watchdog cause");
    acc(1'b0, PMC_A, 8'h00, 1'b0, q);
    chk(q, 32'h0000_0000, "flags after reset");
    $display("test watchdog done");
    enter(8'h02);
    chk(clk_ctrl, 3'h0, "stop clocks");
    irq_req <= 1'b1;
    repeat (20) @(posedge mclk);
    irq_req <= 1'b0;
    chk({sys_reset, clk_ctrl}, 4'h0, "interrupt left stop");
    pin_n <= 1'b0;
    wait_rst(1'b1, 20, n);
    chk(rst_pin_oe, 1'h0, "pin driven on pin reset");
    pin_n <= 1'b1;
    reset_exit();
    chk(pc_cnt, 3, "restart from stop");
    acc(1'b0, RCR_A, 8'h00, 1'b0, q);
    chk(q & 32'h0000_0003, 32'h0000_0001, "pin cause");
    $display("test stop done");
    acc(1'b1, RCR_A, 8'h04, 1'b1, q);
    repeat (2 * MCD_T) @(posedge mclk);
    chk(sys_reset, 1'h0, "detector fired on live clock");
    enter(8'h02);
    wait_rst(1'b1, MCD_T + 10, n);
    reset_exit();
    acc(1'b0, RCR_A, 8'h00, 1'b0, q);
    chk(q & 32'h0000_0004, 32'h0000_0004, "missing clock cause");
    $display("test missing clock done");
    acc(1'b1, SMC_A, 8'h80, 1'b1, q);
    repeat (10) @(posedge mclk);
    acc(1'b1, RCR_A, 8'h02, 1'b1, q);
    supply <= 1'b0;
    wait_rst(1'b1, 20, n);
    chk(rst_pin_oe, 1'h1, "pin on monitor reset");
    supply <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({rst_pin_oe, sys_reset}, 2'h3, "pin released inside reset");
    wait_rst(1'b0, POR_T, n);
    chk(n <= 10, 1'h1, "monitor release delayed");
    repeat (3) @(posedge mclk);
    acc(1'b0, SMC_A, 8'h00, 1'b0, q);
    chk(q[7], 1'h1, "monitor enable lost");
    acc(1'b0, RCR_A, 8'h00, 1'b0, q);
    chk(q[1], 1'h0, "power-on flag kept");
    chk(tick_gap, 12, "watchdog tick spacing");
    $display("test monitor done");
    give_verdict();
  end
endmodule
`default_nettype wire
